/* src/qtimer_pkg.sv */
// Shared constants, register map and state types of the two-phase / one-shot timer channel
package qtimer_pkg;

  // Register byte offsets on the plain register port
  localparam int ADDR_W = 4;
  localparam logic [3:0] ADDR_DATA = 4'h0;
  localparam logic [3:0] ADDR_CTRL = 4'h4;
  localparam logic [3:0] ADDR_MODE = 4'h8;
  localparam logic [3:0] ADDR_STAT = 4'hc;

  // Control register bit positions
  localparam int CTRL_START = 0;
  localparam int CTRL_ONESHOT = 1;
  localparam int CTRL_GP_OUT = 2;
  localparam int CTRL_GP_DRIVE = 3;

  // Status register bit positions
  localparam int STAT_ACTIVE = 0;
  localparam int STAT_IN_LEVEL = 1;
  localparam int STAT_OUT_LEVEL = 2;
  localparam int STAT_DIR_UP = 3;

  // Counter landmarks
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;

  // Prescaler terminal counts
  localparam logic [2:0] PRE8_LAST = 3'h7;
  localparam logic [4:0] PRE32_LAST = 5'h1f;
  localparam logic [4:0] SUB32_LAST = 5'h1f;

  typedef enum logic [0:0] {
    MODE_TWO_PHASE = 1'b0,
    MODE_ONE_SHOT = 1'b1
  } op_mode_t;

  typedef enum logic [1:0] {
    SRC_DIV1 = 2'b00,
    SRC_DIV8 = 2'b01,
    SRC_DIV32 = 2'b10,
    SRC_SUB32 = 2'b11
  } clk_src_t;

  // Mode register layout, bit 0 upward from the right
  typedef struct packed {
    logic trig_from_timer;
    logic trig_from_pin;
    logic trig_fall;
    logic pin_as_pulse;
    clk_src_t src;
    logic free_run;
    logic mul4;
    op_mode_t mode;
  } mode_cfg_t;

  localparam int MODE_W = $bits(mode_cfg_t);

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic in_s1;
    logic in_s2;
    logic in_s3;
    logic out_s1;
    logic out_s2;
    logic out_s3;
    logic sub_s1;
    logic sub_s2;
    logic sub_s3;
    logic [4:0] pre;
    logic [4:0] sub_div;
    logic [15:0] counter;
    logic [15:0] reload;
    logic start;
    logic active;
    logic dir_up;
    logic gp_out;
    logic gp_drive;
    mode_cfg_t cfg;
    logic [31:0] rdata;
    logic irq;
  } state_t;

  localparam state_t STATE_RESET = '0;

endpackage

/* src/qtimer.sv */
// Timer channel: two-phase event counter and one-shot timer with its register port
`timescale 1ns/1ps

module qtimer (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register port
  input wire qtimer_pkg::reg_req_t req,
  output logic [31:0] rdata,
  // Timer pins
  input wire logic timer_input_pin,
  input wire logic timer_output_pin_i,
  output logic timer_output_pin_o,
  output logic timer_output_pin_oe_n,
  // Subclock pin and neighbouring timer
  input wire logic subclock_pin,
  input wire logic other_timer_ovf,
  // Interrupt request
  output logic irq_req
);
  import qtimer_pkg::*;

  // Register map, one 32-bit word each:
  //   DATA  a write sets the reload value, and the counter too while halted;
  //         a read returns the counter
  //   CTRL  bit 0 count start, bit 1 one-shot start (write only, reads zero),
  //         bit 2 port output level, bit 3 port drive enable
  //   MODE  bit 0 one-shot, bit 1 times four, bit 2 free run, bits 4:3 source,
  //         bit 5 pulse output, bit 6 falling trigger, bit 7 pin trigger,
  //         bit 8 timer trigger
  //   STAT  bit 0 one-shot active, bit 1 input level, bit 2 output level,
  //         bit 3 last direction up
  // Limitation: a mode change while counting is not guarded; stop first.
  // Hazard: in times-four mode, both two-phase pins changing in one sample lose that step.
  // Trade-off: div8 and div32 share one free prescaler, so the first tick
  // of a one-shot lands anywhere within one prescaler period.

  state_t s_q;
  state_t s_d;

  logic in_rise;
  logic in_fall;
  logic out_rise;
  logic out_fall;
  logic sub_rise;
  logic two_phase;
  logic running;
  logic step_up;
  logic step_down;
  logic tick;
  logic trig_pin;
  logic trigger;
  logic wr_data;
  logic wr_ctrl;
  logic wr_mode;
  logic halted;

  // Widths the logic below is written for; the package must agree
  localparam int WORD_W = $bits(rdata);
  localparam int CNT_W = $bits(CNT_MAX);
  localparam int PRE_W = $bits(PRE32_LAST);

  logic start_next;
  logic sw_shot;
  logic shot_last;
  logic [WORD_W-1:0] ctrl_word;
  logic [WORD_W-1:0] stat_word;

  // Elaboration checks: every field must fit the data word and the counters
  if (MODE_W > WORD_W) begin : g_mode_fit
    $error("mode fields do not fit the data word");
  end
  if (CNT_W > WORD_W) begin : g_cnt_fit
    $error("counter does not fit the data word");
  end
  if ($bits(PRE8_LAST) > PRE_W) begin : g_pre_fit
    $error("div8 terminal count wider than the prescaler");
  end
  if ($bits(SUB32_LAST) != PRE_W) begin : g_sub_fit
    $error("subclock divider width differs from the prescaler");
  end
  if ($bits(ADDR_DATA) != ADDR_W) begin : g_addr_fit
    $error("register offsets do not match the address width");
  end
  if (CTRL_GP_DRIVE >= WORD_W || STAT_DIR_UP >= WORD_W) begin : g_bit_fit
    $error("control or status bit outside the data word");
  end

  // Rising edge between two synchroniser stages
  function automatic logic rose(input logic now_v, input logic was_v);
    return now_v & ~was_v;
  endfunction

  // Falling edge between two synchroniser stages
  function automatic logic fell(input logic now_v, input logic was_v);
    return ~now_v & was_v;
  endfunction

  // Times four: input level equal to the old output level means up
  function automatic logic quad_up(input logic in_now, input logic out_was);
    return in_now ~^ out_was;
  endfunction

  // Last tick of a one-shot; a set value of zero behaves as one
  function automatic logic last_tick(input logic [15:0] count);
    return count <= CNT_ONE;
  endfunction

  // Control word as software reads it back
  function automatic logic [31:0] ctrl_view(input logic start, input logic gp_out, input logic gp_drive);
    logic [31:0] w;
    w = '0;
    w[CTRL_START] = start;
    w[CTRL_GP_OUT] = gp_out;
    w[CTRL_GP_DRIVE] = gp_drive;
    return w;
  endfunction

  // Status word: synchronised pin levels, never the raw pins
  function automatic logic [31:0] stat_view(input logic active, input logic in_lvl, input logic out_lvl, input logic up);
    logic [31:0] w;
    w = '0;
    w[STAT_ACTIVE] = active;
    w[STAT_IN_LEVEL] = in_lvl;
    w[STAT_OUT_LEVEL] = out_lvl;
    w[STAT_DIR_UP] = up;
    return w;
  endfunction

  // Count source for the one-shot countdown
  function automatic logic src_tick(
    input clk_src_t src,
    input logic [PRE_W-1:0] pre,
    input logic sub_edge,
    input logic [PRE_W-1:0] sub_div
  );
    logic t;
    t = 1'b0;
    unique case (src)
      SRC_DIV1: t = 1'b1;
      SRC_DIV8: t = (pre[$bits(PRE8_LAST)-1:0] == PRE8_LAST);
      SRC_DIV32: t = (pre == PRE32_LAST);
      SRC_SUB32: t = sub_edge & (sub_div == SUB32_LAST);
    endcase
    return t;
  endfunction

  // One two-phase step, with reload (or wrap when free-running) at the ends
  function automatic logic [15:0] two_phase_next(
    input logic up,
    input logic free_run,
    input logic [15:0] count,
    input logic [15:0] reload
  );
    if (up) begin
      if (count == CNT_MAX) begin
        return wrap_or_reload(free_run, CNT_ZERO, reload);
      end
      return count + CNT_ONE;
    end
    if (count == CNT_ZERO) begin
      return wrap_or_reload(free_run, CNT_MAX, reload);
    end
    return count - CNT_ONE;
  endfunction

  assign ctrl_word = ctrl_view(s_q.start, s_q.gp_out, s_q.gp_drive);
  assign stat_word = stat_view(s_q.active, s_q.in_s2, s_q.out_s2, s_q.dir_up);
  assign shot_last = last_tick(s_q.counter);

  // Reload value unless free-running, where the count just wraps
  function automatic logic [15:0] wrap_or_reload(
    input logic free_run,
    input logic [15:0] wrapped,
    input logic [15:0] reload
  );
    if (free_run) begin
      return wrapped;
    end
    return reload;
  endfunction

  // Edges are taken between the second and third stages only
  assign in_rise = rose(s_q.in_s2, s_q.in_s3);
  assign in_fall = fell(s_q.in_s2, s_q.in_s3);
  assign out_rise = rose(s_q.out_s2, s_q.out_s3);
  assign out_fall = fell(s_q.out_s2, s_q.out_s3);
  assign sub_rise = rose(s_q.sub_s2, s_q.sub_s3);

  assign two_phase = (s_q.cfg.mode == MODE_TWO_PHASE);

  // Two-phase counting stops the moment the start flag drops
  assign running = two_phase ? s_q.start : (s_q.start & s_q.active);

  always_comb begin
    step_up = 1'b0;
    step_down = 1'b0;
    if (two_phase && s_q.start) begin
      if (s_q.cfg.mul4) begin
        // Both pins changing in one sample is a lost phase; it is ignored
        if ((in_rise | in_fall) ^ (out_rise | out_fall)) begin
          if (quad_up(s_q.in_s2, s_q.out_s3)) begin
            step_up = 1'b1;
          end else begin
            step_down = 1'b1;
          end
        end
      end else begin
        step_up = in_rise & s_q.out_s2;
        step_down = in_fall & s_q.out_s2;
      end
    end
  end

  assign tick = src_tick(s_q.cfg.src, s_q.pre, sub_rise, s_q.sub_div);

  assign trig_pin = s_q.cfg.trig_fall ? in_fall : in_rise;

  assign wr_data = req.wr && (req.addr == ADDR_DATA);
  assign wr_ctrl = req.wr && (req.addr == ADDR_CTRL);
  assign wr_mode = req.wr && (req.addr == ADDR_MODE);

  // Start flag as it stands after this cycle's write, so that a write of
  // start and one-shot start together triggers at once
  assign start_next = wr_ctrl ? req.wdata[CTRL_START] : s_q.start;
  // Software one-shot start is a write of one; it is never stored
  assign sw_shot = wr_ctrl & req.wdata[CTRL_ONESHOT];

  always_comb begin
    trigger = 1'b0;
    if (!two_phase && start_next) begin
      trigger = (s_q.cfg.trig_from_pin & trig_pin)
        | (s_q.cfg.trig_from_timer & other_timer_ovf)
        | sw_shot;
    end
  end

  // Halted means the start flag is low, or in one-shot mode no one-shot is in flight
  assign halted = ~running;

  always_comb begin
    s_d = s_q;
    s_d.irq = 1'b0;

    // Three stages: the first feeds only the second
    s_d.in_s1 = timer_input_pin;
    s_d.in_s2 = s_q.in_s1;
    s_d.in_s3 = s_q.in_s2;
    s_d.out_s1 = timer_output_pin_i;
    s_d.out_s2 = s_q.out_s1;
    s_d.out_s3 = s_q.out_s2;
    s_d.sub_s1 = subclock_pin;
    s_d.sub_s2 = s_q.sub_s1;
    s_d.sub_s3 = s_q.sub_s2;

    s_d.pre = s_q.pre + 5'h01;
    if (sub_rise) begin
      s_d.sub_div = s_q.sub_div + 5'h01;
    end

    // Register writes
    if (wr_mode) begin
      s_d.cfg = mode_cfg_t'(req.wdata[MODE_W-1:0]);
    end
    if (wr_ctrl) begin
      s_d.start = req.wdata[CTRL_START];
      s_d.gp_out = req.wdata[CTRL_GP_OUT];
      s_d.gp_drive = req.wdata[CTRL_GP_DRIVE];
      if (!req.wdata[CTRL_START]) begin
        s_d.active = 1'b0;
      end
    end
    if (wr_data) begin
      s_d.reload = req.wdata[CNT_W-1:0];
      if (halted) begin
        s_d.counter = req.wdata[CNT_W-1:0];
      end
    end

    if (two_phase) begin
      s_d.active = 1'b0;
      if (step_up || step_down) begin
        s_d.dir_up = step_up;
        // Reload picks up a value written during counting
        s_d.counter = two_phase_next(step_up, s_q.cfg.free_run, s_q.counter, s_d.reload);
        s_d.irq = step_up ? (s_q.counter == CNT_MAX) : (s_q.counter == CNT_ZERO);
      end
    end else if (start_next) begin
      s_d.dir_up = 1'b0;
      if (trigger) begin
        // A trigger mid-count throws away the remaining time
        s_d.counter = s_d.reload;
        s_d.active = 1'b1;
      end else if (s_q.active && tick) begin
        // A set value of zero ends on the first tick, like one
        if (shot_last) begin
          s_d.irq = 1'b1;
          s_d.counter = s_d.reload;
          s_d.active = 1'b0;
        end else begin
          s_d.counter = s_q.counter - CNT_ONE;
        end
      end
    end

    // Read data appear in the cycle after the read strobe
    s_d.rdata = 32'h0000_0000;
    if (req.rd) begin
      unique case (req.addr)
        // One-shot reads give the counter too, but it is mid-flight
        ADDR_DATA: s_d.rdata[15:0] = s_q.counter;
        ADDR_CTRL: s_d.rdata = ctrl_word;
        ADDR_MODE: s_d.rdata[MODE_W-1:0] = s_q.cfg;
        ADDR_STAT: s_d.rdata = stat_word;
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= STATE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // Output pin: input in two-phase mode, else pulse output or port
  always_comb begin
    timer_output_pin_o = 1'b0;
    timer_output_pin_oe_n = 1'b1;
    if (!two_phase) begin
      if (s_q.cfg.pin_as_pulse) begin
        timer_output_pin_o = s_q.active;
        timer_output_pin_oe_n = 1'b0;
      end else if (s_q.gp_drive) begin
        timer_output_pin_o = s_q.gp_out;
        timer_output_pin_oe_n = 1'b0;
      end
    end
  end

  assign rdata = s_q.rdata;
  assign irq_req = s_q.irq;

endmodule

/* tb/qtimer_asserts.sv */
// Port-level property checker for the timer channel
`timescale 1ns/1ps
module qtimer_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register port
  input wire qtimer_pkg::reg_req_t req,
  input wire logic [31:0] rdata,
  // Pins and request
  input wire logic timer_output_pin_o,
  input wire logic timer_output_pin_oe_n,
  input wire logic other_timer_ovf,
  input wire logic irq_req
);
  import qtimer_pkg::*;
  logic st_q, os_q, pu_q, tt_q, gd_q, go_q;

  // Shadow of the control and mode bits, taken from bus writes alone
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {st_q, os_q, pu_q, tt_q, gd_q, go_q} <= '0;
    end else if (req.wr) begin
      if (req.addr == ADDR_CTRL) begin
        {gd_q, go_q, st_q} <= {req.wdata[3:2], req.wdata[0]};
      end
      if (req.addr == ADDR_MODE) begin
        {tt_q, pu_q, os_q} <= {req.wdata[8], req.wdata[5], req.wdata[0]};
      end
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  irq_pulse_a: assert property (irq_req |=> !irq_req) else $error("irq held");
  rdata_idle_a: assert property (!$past(req.rd) |-> rdata == '0) else $error("rdata not idle");
  unmapped_rd_a: assert property (req.rd && req.addr[1:0] != 2'h0 |=> rdata == '0)
    else $error("unmapped read not zero");
  halt_quiet_a: assert property (!st_q && !$past(st_q) |-> !irq_req) else $error("irq while halted");
  two_phase_in_a: assert property (!os_q |-> timer_output_pin_oe_n) else $error("pin driven");
  shot_go_a: assert property (req.wr && req.addr == ADDR_CTRL && req.wdata[1:0] == 2'h3 && os_q && pu_q
    |=> timer_output_pin_o && !timer_output_pin_oe_n) else $error("no pulse after start");
  shot_end_a: assert property (irq_req && os_q && pu_q |-> !timer_output_pin_o && $past(timer_output_pin_o))
    else $error("pulse not ended at zero");
  retrig_a: assert property (other_timer_ovf && os_q && pu_q && tt_q && st_q |=> timer_output_pin_o)
    else $error("timer trigger ignored");
  gp_port_a: assert property (os_q && !pu_q && gd_q |-> !timer_output_pin_oe_n && timer_output_pin_o == go_q)
    else $error("port output wrong");

  cover property (irq_req && !os_q);
  cover property (irq_req && os_q);
  cover property (other_timer_ovf && st_q && os_q);
endmodule

bind qtimer qtimer_asserts qtimer_asserts_i (.clk(clk), .nrst(nrst), .req(req), .rdata(rdata),
  .timer_output_pin_o(timer_output_pin_o), .timer_output_pin_oe_n(timer_output_pin_oe_n),
  .other_timer_ovf(other_timer_ovf), .irq_req(irq_req));

/* tb/qtimer_pins.sv */
// Two-phase pulse source, trigger source and subclock for the timer pins
`timescale 1ns/1ps
module qtimer_pins (
  // Clock
  input wire logic clk,
  // Pin drives
  output logic in_pin,
  output logic out_drv,
  output logic sub_pin
);
  logic [1:0] ph [4] = '{2'b01, 2'b11, 2'b10, 2'b00};
  int i = 0;

  // Subclock runs free at a quarter of clk
  initial begin
    {in_pin, out_drv, sub_pin} = 3'b010;
    forever begin
      repeat (2) @(posedge clk);
      sub_pin <= ~sub_pin;
    end
  end

  // Levels hold four cycles so the synchroniser sees each one
  task step(input bit up, input int n);
    repeat (n) begin
      i = up ? (i + 1) % 4 : (i + 3) % 4;
      {in_pin, out_drv} <= ph[i];
      repeat (4) @(posedge clk);
    end
  endtask

  task trig(input logic v);
    in_pin <= v;
    repeat (4) @(posedge clk);
  endtask
endmodule

/* tb/qtimer_tb.sv */
// Self-checking bench for the timer channel
`timescale 1ns/1ps
module qtimer_tb;
  import qtimer_pkg::*;
  logic clk = 0;
  logic nrst = 0;
  logic oto = 0;
  reg_req_t req = '0;
  logic [31:0] rdata;
  logic in_pin, out_drv, sub_pin, po, poe_n, irq;
  wire out_w = poe_n ? out_drv : po;
  int fails = 0;
  int n_checks = 0;
  int nirq = 0;
  int k, c, s;

  qtimer qtimer_i (.clk(clk), .nrst(nrst), .req(req), .rdata(rdata), .timer_input_pin(in_pin),
    .timer_output_pin_i(out_w), .timer_output_pin_o(po), .timer_output_pin_oe_n(poe_n),
    .subclock_pin(sub_pin), .other_timer_ovf(oto), .irq_req(irq));
  qtimer_pins qtimer_pins_i (.clk(clk), .in_pin(in_pin), .out_drv(out_drv), .sub_pin(sub_pin));

  initial forever #2.5 clk = ~clk;
  always @(posedge clk) if (irq === 1'b1) nirq <= nirq + 1;

  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task wr(input logic [3:0] ad, input logic [31:0] d);
    req <= '{ad, d, 1'b1, 1'b0};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
  endtask

  task rd(input logic [3:0] ad, input logic [15:0] e);
    req <= '{ad, 32'h0, 1'b0, 1'b1};
    @(posedge clk);
    req <= '0;
    #1 chk(rdata, {16'h0, e});
    @(posedge clk);
  endtask

  // Bounded wait; a missing pulse leaves c at the limit
  task wirq;
    c = 0;
    while (irq !== 1'b1 && c < 600) begin
      @(posedge clk);
      c++;
    end
  endtask

  task t_up;
    wr(ADDR_DATA, 32'hfffd);
    rd(ADDR_DATA, 16'hfffd);
    rd(4'h2, 16'h0);
    wr(ADDR_CTRL, 32'h1);
    k = nirq;
    qtimer_pins_i.step(1, 8);
    rd(ADDR_DATA, 16'hffff);
    wr(ADDR_DATA, 32'h0010);
    rd(ADDR_DATA, 16'hffff);
    qtimer_pins_i.step(1, 4);
    rd(ADDR_DATA, 16'h0010);
    chk(nirq - k, 1);
    qtimer_pins_i.step(0, 4);
    rd(ADDR_DATA, 16'h000f);
    wr(ADDR_CTRL, 32'h0);
    qtimer_pins_i.step(1, 8);
    rd(ADDR_DATA, 16'h000f);
  endtask

  task t_x4;
    wr(ADDR_MODE, 32'h2);
    wr(ADDR_DATA, 32'h3);
    wr(ADDR_CTRL, 32'h1);
    k = nirq;
    qtimer_pins_i.step(0, 4);
    rd(ADDR_DATA, 16'h3);
    chk(nirq - k, 1);
    qtimer_pins_i.step(1, 2);
    rd(ADDR_DATA, 16'h5);
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_MODE, 32'h6);
    wr(ADDR_DATA, 32'h1);
    wr(ADDR_CTRL, 32'h1);
    qtimer_pins_i.step(0, 2);
    rd(ADDR_DATA, 16'hffff);
  endtask

  task t_shot;
    for (s = 0; s < 4; s++) begin
      wr(ADDR_CTRL, 32'h0);
      wr(ADDR_MODE, 32'h21 | (s << 3));
      wr(ADDR_DATA, 32'h2);
      wr(ADDR_CTRL, 32'h3);
      wirq;
      k = (s == 0) ? 1 : (s == 1) ? 8 : (s == 2) ? 32 : 128;
      chk(c >= k && c <= 2 * k + 6, 1);
    end
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_MODE, 32'h121);
    wr(ADDR_DATA, 32'h8);
    k = nirq;
    wr(ADDR_CTRL, 32'h3);
    repeat (2) @(posedge clk);
    oto <= 1;
    @(posedge clk);
    oto <= 0;
    wirq;
    chk(c >= 7 && c < 600, 1);
    @(posedge clk);
    chk(nirq - k, 1);
    wr(ADDR_MODE, 32'ha1);
    wr(ADDR_CTRL, 32'h1);
    qtimer_pins_i.trig(0);
    qtimer_pins_i.trig(1);
    @(posedge clk);
    chk(po, 1);
    wirq;
    chk(c < 600, 1);
    wr(ADDR_MODE, 32'h1);
    @(posedge clk);
    k = nirq;
    wr(ADDR_CTRL, 32'h3);
    wr(ADDR_CTRL, 32'hc);
    repeat (20) @(posedge clk);
    chk(nirq - k, 0);
    chk({po, poe_n}, 2'b10);
  endtask

  task stop_test;
    $display("fails=%0d n_checks=%0d", fails, n_checks);
    if (fails == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1;
    @(posedge clk);
    t_up;
    t_x4;
    t_shot;
    stop_test;
  end

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    stop_test;
  end
endmodule
